// file: bench/gpvm_card_model.sv
// plug-in display encoder card seen from the shared graphics port pins
// assumes pin drive values with active-low enables from the multiplexer
`timescale 1ns/1ns
module gpvm_card_model (
  input wire logic link_clock,
  input wire logic card_fitted,
  input wire logic [7:0] card_id,
  input wire logic [31:0] card_pins,
  input wire logic [31:0] gad_out,
  input wire logic [31:0] gad_oe_n,
  input wire logic [4:0] ctl_out,
  input wire logic [4:0] ctl_oe_n,
  output logic gpar_in,
  output logic [7:0] gsba_in,
  output logic [31:0] gad_in,
  output logic [4:0] ctl_in,
  output logic power_good
);
  int stable_cnt = 0;
  assign gpar_in = card_fitted ? 1'b0 : 1'b1;
  assign gsba_in = card_id;
  // a released pin shows the card's own drive; control lines have pull-ups
  assign gad_in = (gad_oe_n & card_pins) | (~gad_oe_n & gad_out);
  assign ctl_in = ctl_oe_n | ctl_out;
  // 10 us of running clock is 667 link cycles at 15 ns
  always_ff @(posedge link_clock) begin
    if (stable_cnt < 667) begin
      stable_cnt <= stable_cnt + 1;
    end
  end
  assign power_good = (stable_cnt >= 667);
endmodule

// file: bench/tb_top.sv
// bench for the graphics port pin multiplexer with a display card model
// assumes register port on clock and pin logic on bus_clock_input
`timescale 1ns/1ns
`include "gpvm_params.svh"
module tb_top;
  import gpvm_pkg::*;
  logic clock, reset, bus_clock_input, reset_input_n, card_fitted, reg_write, reg_read;
  logic clock_enable;
  gpvm_addr_t reg_addr;
  gpvm_word_t reg_wdata, reg_rdata, rd;
  logic [7:0] card_id, gsba_in;
  logic [31:0] card_pins, agp_ad, agp_oe, gad_in, gad_out, gad_oe_n;
  logic [3:0] gcbe_out, gcbe_oe_n;
  logic [1:0] gadstb_out, gadstb_n_out, gadstb_oe_n;
  logic [4:0] ctl_in, ctl_out, ctl_oe_n;
  logic [5:0] ser_out, ser_oe, ser_in;
  gpvm_pixel_t port_b_pixel, port_c_pixel;
  logic port_b_line_sync, port_b_frame_sync, port_b_blank_n;
  logic port_c_line_sync, port_c_frame_sync, port_c_blank_n;
  logic gpar_in, power_good, video_mode, port_b_field_stall, port_c_field_stall;
  logic video_card_interrupt_n, shared_clock_interrupt;
  logic [35:0] pins;
  int fails = 0;
  int samples_checked = 0;
  int bmap[12] = '{3, 2, 5, 4, 7, 6, 8, 32, 10, 9, 12, 11};
  int cmap[12] = '{19, 20, 21, 22, 23, 35, 25, 24, 27, 26, 29, 28};
  assign pins = {gcbe_out, gad_out};

  gpvm_top DUT (.clock, .reset, .clock_enable, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .bus_clock_input, .reset_input_n, .power_good, .gpar_in,
    .gsba_in, .gad_in, .gad_out, .gad_oe_n, .gcbe_out, .gcbe_oe_n, .gadstb_out,
    .gadstb_n_out, .gadstb_oe_n, .ctl_in, .ctl_out, .ctl_oe_n,
    .agp_ad_out(agp_ad), .agp_ad_oe_n(agp_oe), .agp_cbe_out(agp_ad[3:0]),
    .agp_cbe_oe_n(agp_oe[7:4]), .agp_stb_out(agp_ad[9:8]), .agp_stb_n_out(agp_ad[11:10]),
    .agp_stb_oe_n(agp_oe[9:8]), .agp_ctl_out(agp_ad[20:16]), .agp_ctl_oe_n(agp_oe[20:16]),
    .port_b_pixel, .port_b_line_sync, .port_b_frame_sync, .port_b_blank_n,
    .port_c_pixel, .port_c_line_sync, .port_c_frame_sync, .port_c_blank_n,
    .muxed_serial_clock_out(ser_out[0]), .muxed_serial_clock_oe_n(ser_oe[0]),
    .muxed_serial_clock_in(ser_in[0]), .muxed_serial_data_out(ser_out[1]),
    .muxed_serial_data_oe_n(ser_oe[1]), .muxed_serial_data_in(ser_in[1]),
    .muxed_display_id_clock_out(ser_out[2]), .muxed_display_id_clock_oe_n(ser_oe[2]),
    .muxed_display_id_clock_in(ser_in[2]), .muxed_display_id_data_out(ser_out[3]),
    .muxed_display_id_data_oe_n(ser_oe[3]), .muxed_display_id_data_in(ser_in[3]),
    .secondary_display_id_clock_out(ser_out[4]), .secondary_display_id_clock_oe_n(ser_oe[4]),
    .secondary_display_id_clock_in(ser_in[4]), .secondary_display_id_data_out(ser_out[5]),
    .secondary_display_id_data_oe_n(ser_oe[5]), .secondary_display_id_data_in(ser_in[5]),
    .video_mode, .port_b_field_stall, .port_c_field_stall, .video_card_interrupt_n,
    .shared_clock_interrupt);

  gpvm_card_model card (.link_clock(bus_clock_input), .card_fitted, .card_id, .card_pins,
    .gad_out, .gad_oe_n, .ctl_out, .ctl_oe_n, .gpar_in, .gsba_in, .gad_in, .ctl_in,
    .power_good);

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // 15 ns link period; its rising edges land on clock edges, its falling edges 3 ns after one
  initial begin
    bus_clock_input = 0;
    #3;
    forever begin
      #7 bus_clock_input = 1;
      #8 bus_clock_input = 0;
    end
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input gpvm_addr_t a, input gpvm_word_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rchk(input gpvm_addr_t a, input gpvm_word_t exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
    check(rd, exp);
  endtask

  // checks at negedge of the clocks so no update races the sample
  task automatic settle(input int n);
    repeat (n) @(posedge bus_clock_input);
    @(negedge clock);
  endtask

  task automatic chk_port(input int p, input gpvm_pixel_t px, input logic [2:0] s);
    logic [11:0] h;
    int n;
    n = 0;
    // step off the launching edge before the first look at the pins
    @(negedge bus_clock_input);
    while (gadstb_out[p] !== 1'b1 && n < 20) begin
      @(negedge bus_clock_input);
      n++;
    end
    check(p ? {pins[17], pins[16], pins[18]} : {pins[0], pins[1], pins[33]}, s);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 12; i++) h[i] = pins[p ? cmap[i] : bmap[i]];
      check(h, k ? px[23:12] : px[11:0]);
      check({gadstb_out[p], gadstb_n_out[p]}, k ? 2'b01 : 2'b10);
      @(negedge bus_clock_input);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    test_done;
  end

  initial begin
    reset = 1;
    reset_input_n = 0;
    clock_enable = 1;
    reg_write = 0;
    reg_read = 0;
    reg_addr = 0;
    reg_wdata = 0;
    card_fitted = 1;
    card_id = 8'ha5;
    card_pins = 32'h0000_6000;
    agp_ad = 32'h1234_5678;
    agp_oe = 32'h00ff_00f0;
    ser_out = 6'h00;
    ser_oe = 6'h3f;
    {port_b_pixel, port_b_line_sync, port_b_frame_sync, port_b_blank_n} = '0;
    {port_c_pixel, port_c_line_sync, port_c_frame_sync, port_c_blank_n} = '0;
    repeat (8) @(posedge clock);
    check({gadstb_oe_n, ctl_oe_n, gcbe_oe_n, video_mode}, 12'hffe);
    check(gad_oe_n, 32'hffff_ffff);
    reset <= 0;
    reset_input_n <= 1;
    settle(12);
    check(video_mode, 1'b1);
    rchk(`GPVM_STAT_OFS, 32'h3);
    rchk(`GPVM_ID_OFS, 32'ha5);
    rchk(20'h71400, 32'h0);
    rchk(`GPVM_CTRL_OFS, 32'h0);
    @(posedge clock);
    card_fitted <= 0;
    card_id <= 8'h3c;
    settle(8);
    check(video_mode, 1'b1);
    rchk(`GPVM_ID_OFS, 32'ha5);
    card_fitted <= 1;
    reg_wr(`GPVM_CTRL_OFS, 32'h3);
    rchk(`GPVM_CTRL_OFS, 32'h3);
    @(posedge bus_clock_input);
    port_b_pixel <= 24'h5a3c96;
    {port_b_line_sync, port_b_frame_sync, port_b_blank_n} <= 3'b101;
    port_c_pixel <= 24'hc3a5f0;
    {port_c_line_sync, port_c_frame_sync, port_c_blank_n} <= 3'b010;
    repeat (8) @(posedge bus_clock_input);
    chk_port(0, port_b_pixel, {port_b_line_sync, port_b_frame_sync, port_b_blank_n});
    chk_port(1, port_c_pixel, {port_c_line_sync, port_c_frame_sync, port_c_blank_n});
    @(posedge clock);
    ser_oe <= 6'b011110;
    ser_out <= 6'b100000;
    settle(8);
    check({port_b_field_stall, port_c_field_stall}, 2'b10);
    check({video_card_interrupt_n, shared_clock_interrupt}, 2'b01);
    check({ctl_oe_n[4], ctl_out[4], gad_oe_n[15], gad_out[15]}, 4'b0001);
    check(ser_in, 6'h3e);
    // mid-run pin reset must act before any link edge arrives
    @(posedge clock);
    reset_input_n <= 0;
    #1 check({gcbe_oe_n, gad_oe_n}, 36'hf_ffff_ffff);
    check(video_mode, 1'b0);
    card_fitted <= 0;
    repeat (2) @(posedge clock);
    reset_input_n <= 1;
    settle(12);
    check(video_mode, 1'b0);
    check(gad_out, agp_ad);
    check(gad_oe_n, agp_oe);
    rchk(`GPVM_ID_OFS, 32'h0);
    repeat (700) @(posedge bus_clock_input);
    rchk(`GPVM_STAT_OFS, 32'h5);
    // a write while frozen must not land
    clock_enable <= 0;
    reg_wr(`GPVM_CTRL_OFS, 32'h0);
    clock_enable <= 1;
    rchk(`GPVM_CTRL_OFS, 32'h3);
    test_done;
  end
endmodule

// file: core/gpvm_ddr_port.sv
// one digital video port: 24-bit pixel sent as two 12-bit halves per output clock
// assumes pixel and syncs come from logic on link_clock; output clock is link_clock / 2
`timescale 1ns/1ns
module gpvm_ddr_port (
  input wire logic link_clock,
  input wire logic reset_n,
  input wire logic en,
  input wire logic port_on,
  input gpvm_pkg::gpvm_pixel_t pixel,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic blank_n,
  output gpvm_pkg::gpvm_half_t data_q,
  output logic clk_q,
  output logic clk_n_q,
  output logic line_sync_q,
  output logic frame_sync_q,
  output logic blank_n_q
);
  import gpvm_pkg::*;

  gpvm_half_t data_d;
  gpvm_half_t high_q;
  gpvm_half_t high_d;
  logic clk_d;
  logic clk_n_d;
  logic line_sync_d;
  logic frame_sync_d;
  logic blank_n_d;

  // low half leaves with the rising output clock, high half with the falling one
  always_comb begin
    data_d = data_q;
    high_d = high_q;
    clk_d = clk_q;
    clk_n_d = clk_n_q;
    line_sync_d = line_sync_q;
    frame_sync_d = frame_sync_q;
    blank_n_d = blank_n_q;
    if (en) begin
      if (!port_on) begin
        data_d = '0;
        high_d = '0;
        clk_d = 1'b0;
        clk_n_d = 1'b0;
        line_sync_d = 1'b0;
        frame_sync_d = 1'b0;
        blank_n_d = 1'b0;
      end else if (!clk_q) begin
        data_d = pixel[11:0];
        high_d = pixel[23:12];
        clk_d = 1'b1;
        clk_n_d = 1'b0;
        line_sync_d = line_sync;
        frame_sync_d = frame_sync;
        blank_n_d = blank_n;
      end else begin
        data_d = high_q;
        clk_d = 1'b0;
        clk_n_d = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= '0;
      high_q <= '0;
      clk_q <= 1'b0;
      clk_n_q <= 1'b0;
      line_sync_q <= 1'b0;
      frame_sync_q <= 1'b0;
      blank_n_q <= 1'b0;
    end else begin
      data_q <= data_d;
      high_q <= high_d;
      clk_q <= clk_d;
      clk_n_q <= clk_n_d;
      line_sync_q <= line_sync_d;
      frame_sync_q <= frame_sync_d;
      blank_n_q <= blank_n_d;
    end
  end
endmodule

// file: core/gpvm_sync2.sv
// two flip-flop level synchroniser with a freeze enable
// assumes d is a level that stays long enough to be seen; no reset on purpose,
// users wait for the pipe to fill before trusting q
`timescale 1ns/1ns
module gpvm_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = en ? d : meta_q;
    q_d = en ? meta_q : q;
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q <= q_d;
  end
endmodule

// file: core/gpvm_top.sv
// graphics port pin multiplexer: bus pins serve the graphics bus core or two video ports
// assumes the graphics bus core, display pipe and serial masters sit beside it;
// pixel inputs are on bus_clock_input, register port on clock
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "gpvm_params.svh"
module gpvm_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input gpvm_pkg::gpvm_addr_t reg_addr,
  input gpvm_pkg::gpvm_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output gpvm_pkg::gpvm_word_t reg_rdata,
  input wire logic bus_clock_input,
  input wire logic reset_input_n,
  input wire logic power_good,
  input wire logic gpar_in,
  input wire logic [7:0] gsba_in,
  input wire logic [31:0] gad_in,
  output logic [31:0] gad_out,
  output logic [31:0] gad_oe_n,
  output logic [3:0] gcbe_out,
  output logic [3:0] gcbe_oe_n,
  output logic [1:0] gadstb_out,
  output logic [1:0] gadstb_n_out,
  output logic [1:0] gadstb_oe_n,
  input wire logic [4:0] ctl_in,
  output logic [4:0] ctl_out,
  output logic [4:0] ctl_oe_n,
  input wire logic [31:0] agp_ad_out,
  input wire logic [31:0] agp_ad_oe_n,
  input wire logic [3:0] agp_cbe_out,
  input wire logic [3:0] agp_cbe_oe_n,
  input wire logic [1:0] agp_stb_out,
  input wire logic [1:0] agp_stb_n_out,
  input wire logic [1:0] agp_stb_oe_n,
  input wire logic [4:0] agp_ctl_out,
  input wire logic [4:0] agp_ctl_oe_n,
  input gpvm_pkg::gpvm_pixel_t port_b_pixel,
  input wire logic port_b_line_sync,
  input wire logic port_b_frame_sync,
  input wire logic port_b_blank_n,
  input gpvm_pkg::gpvm_pixel_t port_c_pixel,
  input wire logic port_c_line_sync,
  input wire logic port_c_frame_sync,
  input wire logic port_c_blank_n,
  input wire logic muxed_serial_clock_out,
  input wire logic muxed_serial_clock_oe_n,
  output logic muxed_serial_clock_in,
  input wire logic muxed_serial_data_out,
  input wire logic muxed_serial_data_oe_n,
  output logic muxed_serial_data_in,
  input wire logic muxed_display_id_clock_out,
  input wire logic muxed_display_id_clock_oe_n,
  output logic muxed_display_id_clock_in,
  input wire logic muxed_display_id_data_out,
  input wire logic muxed_display_id_data_oe_n,
  output logic muxed_display_id_data_in,
  input wire logic secondary_display_id_clock_out,
  input wire logic secondary_display_id_clock_oe_n,
  output logic secondary_display_id_clock_in,
  input wire logic secondary_display_id_data_out,
  input wire logic secondary_display_id_data_oe_n,
  output logic secondary_display_id_data_in,
  output logic video_mode,
  output logic port_b_field_stall,
  output logic port_c_field_stall,
  output logic video_card_interrupt_n,
  output logic shared_clock_interrupt
);
  import gpvm_pkg::*;

  function automatic logic [`GPVM_PINS-1:0] place_half(
    input logic [`GPVM_MAP_W-1:0] map,
    input gpvm_half_t d,
    input logic [`GPVM_PINS-1:0] base
  );
    logic [`GPVM_PINS-1:0] r;
    r = base;
    for (int i = 0; i < 12; i++) begin
      r[map[6*i +: 6]] = d[i];
    end
    return r;
  endfunction

  // ---------------- link side, on the bus clock ----------------
  logic link_en;
  logic [8:0] strap_s;
  logic [`GPVM_IN_W-1:0] pin_s;
  logic [1:0] port_on_l;
  // port enables live in the register domain; each bit is a level, so a bit-wise pipe is enough
  logic [1:0] ctrl_q, ctrl_d;
  gpvm_strap_t st_q, st_d;
  logic [1:0] fill_q, fill_d;
  logic strap_mode_q, strap_mode_d;
  logic [`GPVM_ID_W-1:0] strap_id_q, strap_id_d;
  logic strap_held;

  // enable crosses too, so both domains freeze with clock_enable low
  gpvm_sync2 #(.W(1)) u_en_sync (.clk(bus_clock_input), .en(1'b1), .d(clock_enable),
    .q(link_en));
  gpvm_sync2 #(.W(9)) u_strap_sync (.clk(bus_clock_input), .en(link_en),
    .d({gpar_in, gsba_in}), .q(strap_s));
  gpvm_sync2 #(.W(`GPVM_IN_W)) u_pin_sync (.clk(bus_clock_input), .en(link_en),
    .d({ctl_in, gad_in[`GPVM_SEC_DATA], gad_in[`GPVM_CLKINT], gad_in[`GPVM_FS_B],
        gad_in[`GPVM_INT], gad_in[`GPVM_FS_C]}), .q(pin_s));
  gpvm_sync2 #(.W(2)) u_ctrl_sync (.clk(bus_clock_input), .en(link_en), .d(ctrl_q),
    .q(port_on_l));

  // wait for the strap pipe to fill, then catch once until the next reset
  always_comb begin
    st_d = st_q;
    fill_d = fill_q;
    strap_mode_d = strap_mode_q;
    strap_id_d = strap_id_q;
    case (st_q)
      STRAP_FILL: begin
        if (link_en) begin
          if (fill_q == `GPVM_SYNC_FILL) begin
            st_d = STRAP_HELD;
            strap_mode_d = strap_s[8];
            strap_id_d = strap_s[7:0];
          end else begin
            fill_d = fill_q + 2'h1;
          end
        end
      end
      STRAP_HELD: st_d = STRAP_HELD;
      default: st_d = STRAP_FILL;
    endcase
  end

  always_ff @(posedge bus_clock_input or negedge reset_input_n) begin
    if (!reset_input_n) begin
      st_q <= STRAP_FILL;
      fill_q <= 2'h0;
      strap_mode_q <= 1'b1;
      strap_id_q <= '0;
    end else begin
      st_q <= st_d;
      fill_q <= fill_d;
      strap_mode_q <= strap_mode_d;
      strap_id_q <= strap_id_d;
    end
  end

  assign strap_held = (st_q == STRAP_HELD);
  assign video_mode = strap_held && (strap_mode_q == `GPVM_VIDEO_STRAP);

  gpvm_half_t pb_data, pc_data;
  logic pb_clk, pb_clk_n, pb_hs, pb_vs, pb_blank_n;
  logic pc_clk, pc_clk_n, pc_hs, pc_vs, pc_blank_n;

  gpvm_ddr_port u_port_b (.link_clock(bus_clock_input), .reset_n(reset_input_n),
    .en(link_en), .port_on(video_mode && port_on_l[`GPVM_CTRL_B]), .pixel(port_b_pixel),
    .line_sync(port_b_line_sync), .frame_sync(port_b_frame_sync), .blank_n(port_b_blank_n),
    .data_q(pb_data), .clk_q(pb_clk), .clk_n_q(pb_clk_n), .line_sync_q(pb_hs),
    .frame_sync_q(pb_vs), .blank_n_q(pb_blank_n));
  gpvm_ddr_port u_port_c (.link_clock(bus_clock_input), .reset_n(reset_input_n),
    .en(link_en), .port_on(video_mode && port_on_l[`GPVM_CTRL_C]), .pixel(port_c_pixel),
    .line_sync(port_c_line_sync), .frame_sync(port_c_frame_sync), .blank_n(port_c_blank_n),
    .data_q(pc_data), .clk_q(pc_clk), .clk_n_q(pc_clk_n), .line_sync_q(pc_hs),
    .frame_sync_q(pc_vs), .blank_n_q(pc_blank_n));

  // video-mode inputs read back only from the synchronised pin copies
  assign port_b_field_stall = video_mode && pin_s[`GPVM_IN_FS_B];
  assign port_c_field_stall = video_mode && pin_s[`GPVM_IN_FS_C];
  assign video_card_interrupt_n = !video_mode || pin_s[`GPVM_IN_INT];
  assign shared_clock_interrupt = video_mode && pin_s[`GPVM_IN_CLKINT];
  assign secondary_display_id_data_in = pin_s[`GPVM_IN_SEC];
  assign muxed_serial_clock_in = pin_s[`GPVM_IN_CTL + `GPVM_IRDY];
  assign muxed_serial_data_in = pin_s[`GPVM_IN_CTL + `GPVM_DEVSEL];
  assign muxed_display_id_clock_in = pin_s[`GPVM_IN_CTL + `GPVM_TRDY];
  assign muxed_display_id_data_in = pin_s[`GPVM_IN_CTL + `GPVM_FRAME];
  assign secondary_display_id_clock_in = pin_s[`GPVM_IN_CTL + `GPVM_STOP];

  logic [`GPVM_PINS-1:0] vid_out, vid_oe_n, pin_out, pin_oe_n;
  logic [4:0] vctl_out, vctl_oe_n;

  always_comb begin
    vid_out = place_half(`GPVM_C_MAP, pc_data,
      place_half(`GPVM_B_MAP, pb_data, '0));
    vid_oe_n = place_half(`GPVM_C_MAP, 12'h000,
      place_half(`GPVM_B_MAP, 12'h000, '1));
    vid_out[`GPVM_HS_B] = pb_hs;
    vid_out[`GPVM_VS_B] = pb_vs;
    vid_out[`GPVM_BLK_B] = pb_blank_n;
    vid_out[`GPVM_HS_C] = pc_hs;
    vid_out[`GPVM_VS_C] = pc_vs;
    vid_out[`GPVM_BLK_C] = pc_blank_n;
    vid_oe_n[`GPVM_HS_B] = 1'b0;
    vid_oe_n[`GPVM_VS_B] = 1'b0;
    vid_oe_n[`GPVM_BLK_B] = 1'b0;
    vid_oe_n[`GPVM_HS_C] = 1'b0;
    vid_oe_n[`GPVM_VS_C] = 1'b0;
    vid_oe_n[`GPVM_BLK_C] = 1'b0;
    vid_out[`GPVM_SEC_DATA] = secondary_display_id_data_out;
    vid_oe_n[`GPVM_SEC_DATA] = secondary_display_id_data_oe_n;
    vctl_out = {muxed_serial_clock_out, muxed_serial_data_out, muxed_display_id_clock_out,
      muxed_display_id_data_out, secondary_display_id_clock_out};
    vctl_oe_n = {muxed_serial_clock_oe_n, muxed_serial_data_oe_n,
      muxed_display_id_clock_oe_n, muxed_display_id_data_oe_n,
      secondary_display_id_clock_oe_n};
    // nothing drives before the straps are known, so a wrong guess cannot fight the card
    if (!reset_input_n || !strap_held) begin
      pin_out = '0;
      pin_oe_n = '1;
      ctl_out = '0;
      ctl_oe_n = '1;
      gadstb_out = '0;
      gadstb_n_out = '0;
      gadstb_oe_n = '1;
    end else if (video_mode) begin
      pin_out = vid_out;
      pin_oe_n = vid_oe_n;
      ctl_out = vctl_out;
      ctl_oe_n = vctl_oe_n;
      gadstb_out = {pc_clk, pb_clk};
      gadstb_n_out = {pc_clk_n, pb_clk_n};
      gadstb_oe_n = 2'h0;
    end else begin
      pin_out = {agp_cbe_out, agp_ad_out};
      pin_oe_n = {agp_cbe_oe_n, agp_ad_oe_n};
      ctl_out = agp_ctl_out;
      ctl_oe_n = agp_ctl_oe_n;
      gadstb_out = agp_stb_out;
      gadstb_n_out = agp_stb_n_out;
      gadstb_oe_n = agp_stb_oe_n;
    end
  end

  assign gad_out = pin_out[31:0];
  assign gad_oe_n = pin_oe_n[31:0];
  assign gcbe_out = pin_out[35:32];
  assign gcbe_oe_n = pin_oe_n[35:32];

  // ---------------- register side, on clock ----------------
  logic [1:0] sys_s;
  logic seen_q, seen_d;
  logic vmode_q, vmode_d;
  logic [`GPVM_ID_W-1:0] id_q, id_d;
  gpvm_word_t rdata_q, rdata_d;

  gpvm_sync2 #(.W(2)) u_sys_sync (.clk(clock), .en(clock_enable),
    .d({power_good, strap_held}), .q(sys_s));

  // strap words are frozen once held is seen, so sampling them here is safe
  always_comb begin
    ctrl_d = ctrl_q;
    seen_d = seen_q;
    vmode_d = vmode_q;
    id_d = id_q;
    rdata_d = rdata_q;
    if (clock_enable) begin
      rdata_d = '0;
      if (sys_s[0] && !seen_q) begin
        seen_d = 1'b1;
        vmode_d = (strap_mode_q == `GPVM_VIDEO_STRAP);
        id_d = (strap_mode_q == `GPVM_VIDEO_STRAP) ? strap_id_q : '0;
      end else if (!sys_s[0]) begin
        seen_d = 1'b0;
        vmode_d = 1'b0;
        id_d = '0;
      end
      if (reg_write && reg_addr == `GPVM_CTRL_OFS) begin
        ctrl_d = reg_wdata[1:0];
      end
      if (reg_read) begin
        case (reg_addr)
          `GPVM_ID_OFS: rdata_d[`GPVM_ID_W-1:0] = id_q;
          `GPVM_STAT_OFS: begin
            rdata_d[`GPVM_STAT_VALID] = seen_q;
            rdata_d[`GPVM_STAT_VIDEO] = vmode_q;
            rdata_d[`GPVM_STAT_POWER_GOOD] = sys_s[1];
          end
          `GPVM_CTRL_OFS: rdata_d[1:0] = ctrl_q;
          default: rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q <= `GPVM_CTRL_RST;
      seen_q <= 1'b0;
      vmode_q <= 1'b0;
      id_q <= '0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      seen_q <= seen_d;
      vmode_q <= vmode_d;
      id_q <= id_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- checks ----------------
  logic b_live;
  assign b_live = video_mode && link_en && port_on_l[`GPVM_CTRL_B];

  sequence b_low_s;
    pb_clk && pb_data == $past(port_b_pixel[11:0]);
  endsequence
  sequence b_high_s;
    !pb_clk && pb_data == $past(port_b_pixel[23:12], 2);
  endsequence

  reset_tristate_a: assert property (@(posedge clock) disable iff (reset)
    !reset_input_n |-> (&gad_oe_n) && (&gcbe_oe_n) && (&ctl_oe_n) && (&gadstb_oe_n))
    else $error("pins driven during reset");
  async_clear_a: assert property (@(posedge clock) disable iff (reset)
    !reset_input_n |-> !strap_held && !video_mode && !pb_clk && !pc_clk)
    else $error("pin logic not cleared by reset input");
  strap_hold_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    strap_held && $past(strap_held) |-> $stable(strap_id_q) && $stable(strap_mode_q))
    else $error("straps changed while held");
  mode_select_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    $rose(strap_held) |-> video_mode == ($past(strap_s[8]) == `GPVM_VIDEO_STRAP))
    else $error("video mode does not follow strap");
  bus_pass_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    strap_held && !video_mode |-> gad_out == agp_ad_out && gcbe_oe_n == agp_cbe_oe_n)
    else $error("bus mode pins not passed through");
  port_b_pins_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    video_mode |-> gad_out[3] == pb_data[0] && gcbe_out[0] == pb_data[7]
      && gad_out[12] == pb_data[10] && gadstb_out[0] == pb_clk && !gad_oe_n[3])
    else $error("port B pin placement wrong");
  port_c_pins_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    video_mode |-> gad_out[19] == pc_data[0] && gcbe_out[3] == pc_data[5]
      && gad_out[28] == pc_data[11] && gad_out[17] == pc_hs && gadstb_n_out[1] == pc_clk_n)
    else $error("port C pin placement wrong");
  side_pins_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    video_mode |-> gad_oe_n[13] && gad_oe_n[14] && gad_oe_n[30] && gad_oe_n[31]
      && ctl_out[4] == muxed_serial_clock_out && ctl_oe_n[1] == muxed_display_id_data_oe_n)
    else $error("side signal pins wrong");
  ddr_halves_a: assert property (@(posedge bus_clock_input) disable iff (!reset_input_n)
    $rose(pb_clk) && b_live |-> b_low_s ##1 b_high_s)
    else $error("port B halves out of order");
  id_read_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && clock_enable && reg_addr == `GPVM_ID_OFS && seen_q && vmode_q
      |=> reg_rdata == {24'h0, strap_id_q})
    else $error("card identifier read wrong");
endmodule

// file: inc/gpvm_params.svh
// constants of the graphics port / video output pin multiplexer
// assumes inclusion by bare name from inc/, no logic here
`ifndef GPVM_PARAMS_SVH
`define GPVM_PARAMS_SVH

// register map, byte addresses on the plain register port
`define GPVM_ADDR_W 20
`define GPVM_ID_OFS 20'h71408
`define GPVM_STAT_OFS 20'h7140c
`define GPVM_CTRL_OFS 20'h71410
`define GPVM_CTRL_RST 2'h0
`define GPVM_CTRL_B 0
`define GPVM_CTRL_C 1
`define GPVM_STAT_VALID 0
`define GPVM_STAT_VIDEO 1
`define GPVM_STAT_POWER_GOOD 2
`define GPVM_ID_W 8

// mode strap level that means a plug-in display card is fitted
`define GPVM_VIDEO_STRAP 1'b0
// enabled link cycles after reset release before the strap pipe holds pin levels
`define GPVM_SYNC_FILL 2'h2

// pin vector: bits 31:0 are the address/data pins, 35:32 the byte enables
`define GPVM_PINS 36
`define GPVM_MAP_W 72
`define GPVM_B_MAP {6'd11, 6'd12, 6'd9, 6'd10, 6'd32, 6'd8, 6'd6, 6'd7, 6'd4, 6'd5, 6'd2, 6'd3}
`define GPVM_C_MAP {6'd28, 6'd29, 6'd26, 6'd27, 6'd24, 6'd25, 6'd35, 6'd23, 6'd22, 6'd21, 6'd20, 6'd19}
`define GPVM_HS_B 0
`define GPVM_VS_B 1
`define GPVM_BLK_B 33
`define GPVM_CLKINT 13
`define GPVM_FS_B 14
`define GPVM_SEC_DATA 15
`define GPVM_VS_C 16
`define GPVM_HS_C 17
`define GPVM_BLK_C 18
`define GPVM_INT 30
`define GPVM_FS_C 31

// control pin vector order
`define GPVM_IRDY 4
`define GPVM_DEVSEL 3
`define GPVM_TRDY 2
`define GPVM_FRAME 1
`define GPVM_STOP 0

// synchronised pin input vector order
`define GPVM_IN_W 10
`define GPVM_IN_FS_C 0
`define GPVM_IN_INT 1
`define GPVM_IN_FS_B 2
`define GPVM_IN_CLKINT 3
`define GPVM_IN_SEC 4
`define GPVM_IN_CTL 5

`endif

// file: inc/gpvm_pkg.sv
// types shared by the pin multiplexer files
// assumes gpvm_params.svh for all numeric constants
package gpvm_pkg;
  typedef logic [19:0] gpvm_addr_t;
  typedef logic [31:0] gpvm_word_t;
  typedef logic [23:0] gpvm_pixel_t;
  typedef logic [11:0] gpvm_half_t;
  typedef enum logic {STRAP_FILL, STRAP_HELD} gpvm_strap_t;
endpackage
